/* rtl/pto_params.svh */
`ifndef PTO_PARAMS_SVH
`define PTO_PARAMS_SVH
// Register byte offsets
`define PTO_OFF_CTRL 12'h000
`define PTO_OFF_PERIOD 12'h004
`define PTO_OFF_WIDTH 12'h008
`define PTO_OFF_STATUS 12'h00c
`define PTO_OFF_COUNT 12'h010
// Control field positions
`define PTO_CTRL_RUN 0
`define PTO_CTRL_CLKSEL 1
`define PTO_CTRL_MODE_LO 8
`define PTO_CTRL_MODE_HI 12
// Mode encodings
`define PTO_MODE_GATE 5'h00
`define PTO_MODE_ONE_SW 5'h08
`define PTO_MODE_ONE_RISE 5'h09
`define PTO_MODE_ONE_FALL 5'h0a
`define PTO_MODE_ONE_BOTH 5'h0b
// Reset values
`define PTO_RST_PERIOD 8'hff
`define PTO_RST_WIDTH 8'h00
// Instruction clock ticks when the divider reaches this, giving the system clock divided by four
`define PTO_ICLK_DIV 2'h3
`endif

/* rtl/pto_pkg.sv */
package pto_pkg;
   typedef enum logic [1:0] {
      PTO_IDLE = 2'b00,
      PTO_ARMED = 2'b01,
      PTO_RUN = 2'b10,
      PTO_DONE = 2'b11
   } pto_state_t;
endpackage : pto_pkg

/* rtl/pto_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser, advanced only on enable ticks of its domain
module pto_sync (
   input wire logic clk_sys_i, // System clock
   input wire logic srst_i, // Synchronous reset
   input wire logic tick_i, // Advance enable
   input wire logic d_i, // Asynchronous level
   output logic q_o // Synchronised level
);
   typedef struct packed {
      logic s1;
      logic s2;
   } pto_sync_t;
   pto_sync_t st_q;
   pto_sync_t st_d;
   always_comb begin
      st_d = st_q;
      if (tick_i) begin
         st_d.s1 = d_i;
         st_d.s2 = st_q.s1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign q_o = st_q.s2;
endmodule : pto_sync

/* rtl/pto_axil.sv */
`timescale 1ns/1ps
`include "pto_params.svh"
// AXI4-Lite slave front end: latches AW and W independently, answers reads in one cycle and writes in two
module pto_axil (
   input wire logic clk_sys_i, // System clock
   input wire logic srst_i, // Synchronous reset
   input wire logic [11:0] s_axil_awaddr, // Write address
   input wire logic s_axil_awvalid, // Write address valid
   output logic s_axil_awready, // Write address ready
   input wire logic [31:0] s_axil_wdata, // Write data
   input wire logic [3:0] s_axil_wstrb, // Write strobes
   input wire logic s_axil_wvalid, // Write data valid
   output logic s_axil_wready, // Write data ready
   output logic [1:0] s_axil_bresp, // Write response
   output logic s_axil_bvalid, // Write response valid
   input wire logic s_axil_bready, // Write response ready
   input wire logic [11:0] s_axil_araddr, // Read address
   input wire logic s_axil_arvalid, // Read address valid
   output logic s_axil_arready, // Read address ready
   output logic [31:0] s_axil_rdata, // Read data
   output logic [1:0] s_axil_rresp, // Read response
   output logic s_axil_rvalid, // Read valid
   input wire logic s_axil_rready, // Read ready
   output logic wr_en_o, // Write pulse to register file
   output logic [11:0] wr_addr_o, // Write word address
   output logic [31:0] wr_data_o, // Write data
   output logic [3:0] wr_strb_o, // Write strobes
   input wire logic wr_ok_i, // Write address is mapped
   output logic [11:0] rd_addr_o, // Read address to register file
   input wire logic [31:0] rd_data_i, // Read data from register file
   input wire logic rd_ok_i // Read address is mapped
);
   typedef struct packed {
      logic aw_full;
      logic [11:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pto_axil_t;
   pto_axil_t st_q;
   pto_axil_t st_d;
   logic do_wr;
   assign s_axil_awready = !st_q.aw_full;
   assign s_axil_wready = !st_q.w_full;
   assign s_axil_arready = !st_q.rvalid;
   assign do_wr = st_q.aw_full && st_q.w_full && !st_q.bvalid;
   assign wr_en_o = do_wr && wr_ok_i;
   assign wr_addr_o = {st_q.aw_addr[11:2], 2'b00};
   assign wr_data_o = st_q.w_data;
   assign wr_strb_o = st_q.w_strb;
   assign rd_addr_o = {s_axil_araddr[11:2], 2'b00};
   always_comb begin
      st_d = st_q;
      if (s_axil_awvalid && !st_q.aw_full) begin
         st_d.aw_full = 1'b1;
         st_d.aw_addr = s_axil_awaddr;
      end
      if (s_axil_wvalid && !st_q.w_full) begin
         st_d.w_full = 1'b1;
         st_d.w_data = s_axil_wdata;
         st_d.w_strb = s_axil_wstrb;
      end
      if (do_wr) begin
         st_d.aw_full = 1'b0;
         st_d.w_full = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = wr_ok_i ? 2'h0 : 2'h2;
      end
      if (st_q.bvalid && s_axil_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && s_axil_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (s_axil_arvalid && !st_q.rvalid) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rd_ok_i ? rd_data_i : 32'h0000_0000;
         st_d.rresp = rd_ok_i ? 2'h0 : 2'h2;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign s_axil_bvalid = st_q.bvalid;
   assign s_axil_bresp = st_q.bresp;
   assign s_axil_rvalid = st_q.rvalid;
   assign s_axil_rdata = st_q.rdata;
   assign s_axil_rresp = st_q.rresp;
endmodule : pto_axil

/* rtl/pto_timer.sv */
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pto_params.svh"
module pto_timer (
   input wire logic clk_sys_i, // System clock, 10 MHz
   input wire logic srst_i, // Synchronous reset, active high
   input wire logic timer_clock_input_i, // External timer clock pin
   input wire logic external_start_input_i, // External start pin
   input wire logic [11:0] s_axil_awaddr, // AXI write address
   input wire logic s_axil_awvalid, // AXI write address valid
   output logic s_axil_awready, // AXI write address ready
   input wire logic [31:0] s_axil_wdata, // AXI write data
   input wire logic [3:0] s_axil_wstrb, // AXI write strobes
   input wire logic s_axil_wvalid, // AXI write data valid
   output logic s_axil_wready, // AXI write data ready
   output logic [1:0] s_axil_bresp, // AXI write response
   output logic s_axil_bvalid, // AXI write response valid
   input wire logic s_axil_bready, // AXI write response ready
   input wire logic [11:0] s_axil_araddr, // AXI read address
   input wire logic s_axil_arvalid, // AXI read address valid
   output logic s_axil_arready, // AXI read address ready
   output logic [31:0] s_axil_rdata, // AXI read data
   output logic [1:0] s_axil_rresp, // AXI read response
   output logic s_axil_rvalid, // AXI read valid
   input wire logic s_axil_rready, // AXI read ready
   output logic [7:0] timer_count_o, // Current count
   output logic pwm_drive_o, // PWM pulse drive
   output logic pwm_period_start_o, // Period-start pulse to PWM
   output logic divided_match_output_o // Period match pulse
);
   // ==========================================
   // State
   // ==========================================
   typedef struct packed {
      logic run;
      logic clk_sel;
      logic [4:0] mode;
      logic [7:0] period_value;
      logic [7:0] pulse_width_value;
      logic [7:0] timer_count;
      logic pwm_drive;
      logic pset;
      logic match;
      logic [1:0] div;
      logic tclk_s3;
      logic ers_prev;
      logic run_d1;
      logic run_eff;
      pto_pkg::pto_state_t os_state;
   } pto_timer_t;
   pto_timer_t st_q;
   pto_timer_t st_d;
   logic wr_en;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ok;
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_ok;
   logic tclk_sync;
   logic ers_sync_ext;
   logic ers_sync_int;
   logic run_sync_ext;
   logic iclk_tick;
   logic ext_tick;
   logic tick;
   logic run_in;
   logic ers_in;
   logic edge_hit;
   logic one_shot;
   logic edge_mode;
   logic at_period;
   // ==========================================
   // Bus slave
   // ==========================================
   pto_axil u_axil (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .s_axil_awaddr(s_axil_awaddr),
      .s_axil_awvalid(s_axil_awvalid),
      .s_axil_awready(s_axil_awready),
      .s_axil_wdata(s_axil_wdata),
      .s_axil_wstrb(s_axil_wstrb),
      .s_axil_wvalid(s_axil_wvalid),
      .s_axil_wready(s_axil_wready),
      .s_axil_bresp(s_axil_bresp),
      .s_axil_bvalid(s_axil_bvalid),
      .s_axil_bready(s_axil_bready),
      .s_axil_araddr(s_axil_araddr),
      .s_axil_arvalid(s_axil_arvalid),
      .s_axil_arready(s_axil_arready),
      .s_axil_rdata(s_axil_rdata),
      .s_axil_rresp(s_axil_rresp),
      .s_axil_rvalid(s_axil_rvalid),
      .s_axil_rready(s_axil_rready),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_ok_i(wr_ok),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_ok_i(rd_ok)
   );
   // Status and count are read-only
   assign wr_ok = (wr_addr == `PTO_OFF_CTRL) ||
                  (wr_addr == `PTO_OFF_PERIOD) ||
                  (wr_addr == `PTO_OFF_WIDTH);
   always_comb begin
      rd_ok = 1'b1;
      rd_data = 32'h0000_0000;
      case (rd_addr)
         `PTO_OFF_CTRL: begin
            rd_data[`PTO_CTRL_RUN] = st_q.run;
            rd_data[`PTO_CTRL_CLKSEL] = st_q.clk_sel;
            rd_data[`PTO_CTRL_MODE_HI:`PTO_CTRL_MODE_LO] = st_q.mode;
         end
         `PTO_OFF_PERIOD: begin
            rd_data[7:0] = st_q.period_value;
         end
         `PTO_OFF_WIDTH: begin
            rd_data[7:0] = st_q.pulse_width_value;
         end
         `PTO_OFF_STATUS: begin
            rd_data[3:0] = {st_q.os_state, st_q.run_eff, st_q.pwm_drive};
         end
         `PTO_OFF_COUNT: begin
            rd_data[7:0] = st_q.timer_count;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end
   // ==========================================
   // Synchronisers
   // ==========================================
   pto_sync u_sync_tclk (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .tick_i(1'b1),
      .d_i(timer_clock_input_i),
      .q_o(tclk_sync)
   );
   // One tick per rising pin edge
   assign ext_tick = tclk_sync && !st_q.tclk_s3;
   assign iclk_tick = (st_q.div == `PTO_ICLK_DIV);
   assign tick = st_q.clk_sel ? ext_tick : iclk_tick;
   // Run and start pass two timer clocks on the external clock
   pto_sync u_sync_run (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .tick_i(ext_tick),
      .d_i(st_q.run),
      .q_o(run_sync_ext)
   );
   pto_sync u_sync_ers_ext (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .tick_i(ext_tick),
      .d_i(external_start_input_i),
      .q_o(ers_sync_ext)
   );
   // Pin still needs the full two-flop guard on the instruction clock
   pto_sync u_sync_ers_int (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .tick_i(1'b1),
      .d_i(external_start_input_i),
      .q_o(ers_sync_int)
   );
   assign run_in = st_q.clk_sel ? run_sync_ext : st_q.run_d1;
   assign ers_in = st_q.clk_sel ? ers_sync_ext : ers_sync_int;
   // ==========================================
   // Mode decode
   // ==========================================
   assign one_shot = (st_q.mode == `PTO_MODE_ONE_SW) ||
                     edge_mode;
   assign edge_mode = (st_q.mode == `PTO_MODE_ONE_RISE) || (st_q.mode == `PTO_MODE_ONE_FALL) ||
                      (st_q.mode == `PTO_MODE_ONE_BOTH);
   always_comb begin
      case (st_q.mode)
         `PTO_MODE_ONE_RISE: begin
            edge_hit = ers_in && !st_q.ers_prev;
         end
         `PTO_MODE_ONE_FALL: begin
            edge_hit = !ers_in && st_q.ers_prev;
         end
         `PTO_MODE_ONE_BOTH: begin
            edge_hit = ers_in != st_q.ers_prev;
         end
         default: begin
            edge_hit = 1'b0;
         end
      endcase
   end
   assign at_period = (st_q.timer_count == st_q.period_value);
   // ==========================================
   // Next state
   // ==========================================
   always_comb begin
      st_d = st_q;
      st_d.pset = 1'b0;
      st_d.match = 1'b0;
      st_d.tclk_s3 = tclk_sync;
      st_d.div = iclk_tick ? 2'h0 : st_q.div + 2'h1;
      // Run seen once per instruction period
      if (iclk_tick) begin
         st_d.run_d1 = st_q.run;
      end
      if (tick) begin
         st_d.ers_prev = ers_in;
         st_d.run_eff = run_in;
         if (!one_shot) begin
            st_d.os_state = pto_pkg::PTO_IDLE;
            if (run_in) begin
               if (at_period) begin
                  st_d.timer_count = 8'h00;
                  st_d.match = 1'b1;
                  st_d.pset = 1'b1;
                  st_d.pwm_drive = 1'b1;
               end else begin
                  st_d.timer_count = st_q.timer_count + 8'h01;
               end
               // Gate drive: set at wrap, off at width
               if (st_q.timer_count == st_q.pulse_width_value) begin
                  st_d.pwm_drive = 1'b0;
               end
            end
         end else begin
            case (st_q.os_state)
               pto_pkg::PTO_IDLE, pto_pkg::PTO_DONE: begin
                  st_d.timer_count = 8'h00;
                  // Software relaunch required each cycle
                  // Done holds until the cleared run gets through
                  if (!run_in) begin
                     st_d.os_state = pto_pkg::PTO_IDLE;
                  end else if (st_q.os_state == pto_pkg::PTO_IDLE) begin
                     if (edge_mode) begin
                        st_d.os_state = pto_pkg::PTO_ARMED;
                     end else begin
                        st_d.os_state = pto_pkg::PTO_RUN;
                        st_d.pwm_drive = 1'b1;
                        st_d.pset = 1'b1;
                     end
                  end
               end
               pto_pkg::PTO_ARMED: begin
                  // Needs run and a fresh edge
                  if (run_in && edge_hit) begin
                     st_d.os_state = pto_pkg::PTO_RUN;
                     st_d.pwm_drive = 1'b1;
                     st_d.pset = 1'b1;
                  end
               end
               pto_pkg::PTO_RUN: begin
                  if (!run_in) begin
                     // Count pauses, drive stays as is
                     if (edge_mode) begin
                        st_d.os_state = pto_pkg::PTO_ARMED;
                     end
                  end else if (at_period) begin
                     st_d.timer_count = 8'h00;
                     st_d.pwm_drive = 1'b0;
                     st_d.match = 1'b1;
                     st_d.os_state = pto_pkg::PTO_DONE;
                  end else begin
                     st_d.timer_count = st_q.timer_count + 8'h01;
                     if (st_q.timer_count + 8'h01 == st_q.pulse_width_value) begin
                        st_d.pwm_drive = 1'b0;
                     end
                  end
               end
               default: begin
                  st_d.os_state = pto_pkg::PTO_IDLE;
               end
            endcase
         end
      end
      // Hardware clear of run; a same-cycle software write wins, a fresh start on the instruction clock only (external clock stays in done)
      if (tick && one_shot && run_in && at_period && st_q.os_state == pto_pkg::PTO_RUN) begin
         st_d.run = 1'b0;
         st_d.run_d1 = 1'b0;
      end
      if (wr_en) begin
         case (wr_addr)
            `PTO_OFF_CTRL: begin
               if (wr_strb[0]) begin
                  st_d.run = wr_data[`PTO_CTRL_RUN];
                  st_d.clk_sel = wr_data[`PTO_CTRL_CLKSEL];
               end
               if (wr_strb[1]) begin
                  st_d.mode = wr_data[`PTO_CTRL_MODE_HI:`PTO_CTRL_MODE_LO];
               end
            end
            `PTO_OFF_PERIOD: begin
               if (wr_strb[0]) begin
                  st_d.period_value = wr_data[7:0];
               end
            end
            `PTO_OFF_WIDTH: begin
               if (wr_strb[0]) begin
                  st_d.pulse_width_value = wr_data[7:0];
               end
            end
            default: begin
               st_d.run = st_d.run;
            end
         endcase
      end
   end
   // Period leaves reset at full scale
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         st_q <= '0;
         st_q.period_value <= `PTO_RST_PERIOD;
         st_q.pulse_width_value <= `PTO_RST_WIDTH;
         st_q.os_state <= pto_pkg::PTO_IDLE;
      end else begin
         st_q <= st_d;
      end
   end
   assign timer_count_o = st_q.timer_count;
   assign pwm_drive_o = st_q.pwm_drive;
   assign pwm_period_start_o = st_q.pset;
   assign divided_match_output_o = st_q.match;
endmodule : pto_timer

/* dv/pto_timer_checker.sv */
`timescale 1ns/1ps
// ==========
// Port checks on the timer top
module pto_timer_checker (
   input wire logic clk_sys_i, // System clock
   input wire logic srst_i, // Synchronous reset
   input wire logic s_axil_awvalid, // Write address valid
   input wire logic s_axil_awready, // Write address ready
   input wire logic s_axil_wvalid, // Write data valid
   input wire logic s_axil_wready, // Write data ready
   input wire logic s_axil_bvalid, // Write response valid
   input wire logic s_axil_arvalid, // Read address valid
   input wire logic s_axil_arready, // Read address ready
   input wire logic [31:0] s_axil_rdata, // Read data
   input wire logic s_axil_rvalid, // Read valid
   input wire logic s_axil_rready, // Read ready
   input wire logic [7:0] timer_count_o, // Current count
   input wire logic pwm_drive_o, // PWM drive
   input wire logic pwm_period_start_o, // Period-start pulse
   input wire logic divided_match_output_o // Match pulse
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   a_match_one_cycle: assert property (divided_match_output_o |=> !divided_match_output_o)
      else $error("match pulse longer than one cycle");
   a_pset_one_cycle: assert property (pwm_period_start_o |=> !pwm_period_start_o)
      else $error("period start pulse longer than one cycle");
   a_count_step: assert property ($changed(timer_count_o) |->
      (timer_count_o == $past(timer_count_o) + 8'h01) || (timer_count_o == 8'h00))
      else $error("count moved other than up by one or to zero");
   a_count_spacing: assert property ($changed(timer_count_o) |=> $stable(timer_count_o))
      else $error("count changed on two cycles in a row");
   a_drive_start: assert property ($rose(pwm_drive_o) |-> pwm_period_start_o)
      else $error("drive rose without a cycle start");
   a_rdata_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
      else $error("read answer dropped or changed before taken");
   a_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
      else $error("read address accepted while answer pending");
   a_write_answer: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
      |-> ##[1:2] s_axil_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
      else $error("read answer late");
endmodule : pto_timer_checker
bind pto_timer pto_timer_checker pto_timer_checker_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
   .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
   .s_axil_wready(s_axil_wready), .s_axil_bvalid(s_axil_bvalid), .s_axil_arvalid(s_axil_arvalid),
   .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rvalid(s_axil_rvalid),
   .s_axil_rready(s_axil_rready), .timer_count_o(timer_count_o), .pwm_drive_o(pwm_drive_o),
   .pwm_period_start_o(pwm_period_start_o), .divided_match_output_o(divided_match_output_o));

/* dv/pto_ext_model.sv */
`timescale 1ns/1ps
// ==========
// External timer clock and start pin
module pto_ext_model (
   input wire logic clk_sys_i, // System clock
   input wire logic clk_en_i, // Run the external clock
   input wire logic start_lvl_i, // Wanted start pin level
   output logic timer_clock_input_o, // External timer clock
   output logic external_start_input_o // External start pin
);
   logic [1:0] div_q = 2'h0;
   initial timer_clock_input_o = 1'b0;
   initial external_start_input_o = 1'b0;
   // Clock stands low when stopped, six system clocks a period
   always @(posedge clk_sys_i) begin
      if (!clk_en_i) begin
         div_q <= 2'h0;
         timer_clock_input_o <= 1'b0;
      end else if (div_q == 2'h2) begin
         div_q <= 2'h0;
         timer_clock_input_o <= ~timer_clock_input_o;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   // Pin moves half a cycle off the edge, as an unrelated source would
   always @(negedge clk_sys_i) external_start_input_o <= start_lvl_i;
endmodule : pto_ext_model

/* dv/testbench.sv */
`timescale 1ns/1ps
`include "pto_params.svh"
module testbench;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, drv, pset, match, tclk, tstart;
   logic [1:0] bresp, rresp;
   logic [7:0] cnt;
   logic ext_en = 1'b0, lvl = 1'b0;
   int err_total = 0, cmp_count = 0, cycles = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   pto_timer pto_timer_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .timer_clock_input_i(tclk),
      .external_start_input_i(tstart), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
      .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
      .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
      .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
      .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .timer_count_o(cnt),
      .pwm_drive_o(drv), .pwm_period_start_o(pset), .divided_match_output_o(match));
   pto_ext_model pto_ext_model_inst (.clk_sys_i(clk_sys_i), .clk_en_i(ext_en), .start_lvl_i(lvl),
      .timer_clock_input_o(tclk), .external_start_input_o(tstart));
   // ==========
   // Shared tasks
   task conclude();
      if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         err_total++;
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : cyc
   function automatic logic [31:0] ctrl(input logic [4:0] m, input logic ck, input logic run);
      ctrl = {19'h0, m, 6'h0, ck, run};
   endfunction : ctrl
   task do_reset();
      @(posedge clk_sys_i);
      srst_i <= 1'b1;
      ext_en <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      srst_i <= 1'b0;
   endtask : do_reset
   // Ready is sampled at the falling edge so the next rising edge sees the same value
   task axw(input logic [11:0] a, input logic [31:0] d);
      logic ad, wd, bd;
      ad = 0;
      wd = 0;
      bd = 0;
      @(posedge clk_sys_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bd) begin
         @(negedge clk_sys_i);
         if (awvalid && awready) ad = 1;
         if (wvalid && wready) wd = 1;
         bd = bvalid;
         @(posedge clk_sys_i);
         if (ad) awvalid <= 1'b0;
         if (wd) wvalid <= 1'b0;
         if (bd) bready <= 1'b0;
      end
   endtask : axw
   // Rready rises with the request, falls once rvalid is seen
   task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ad, rd;
      ad = 0;
      rd = 0;
      @(posedge clk_sys_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rd) begin
         @(negedge clk_sys_i);
         if (arvalid && arready) ad = 1;
         rd = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk_sys_i);
         if (ad) arvalid <= 1'b0;
         if (rd) rready <= 1'b0;
      end
   endtask : axr
   task wait_hi(input logic sel, input int lim);
      logic seen;
      int n;
      seen = 0;
      n = 0;
      while (!seen && n < lim) begin
         cyc(1);
         seen = sel ? match : drv;
         n++;
      end
      chk(32'(seen), 32'h1);
   endtask : wait_hi
   task wait_chg(input int lim);
      logic [7:0] old;
      int n;
      old = cnt;
      n = 0;
      while (cnt === old && n < lim) begin
         cyc(1);
         n++;
      end
   endtask : wait_chg
   // ==========
   // Scenarios
   task t_gate();
      logic [31:0] d;
      logic [1:0] r;
      do_reset();
      axr(`PTO_OFF_PERIOD, d, r);
      chk(d, 32'h0000_00ff);
      axr(`PTO_OFF_WIDTH, d, r);
      chk(d, 32'h0);
      axr(12'h020, d, r);
      chk(32'(r), 32'h2);
      chk(d, 32'h0);
      axw(12'h020, 32'h0);
      chk(32'(bresp), 32'h2);
      axw(`PTO_OFF_PERIOD, 32'h3);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_GATE, 1'b0, 1'b1));
      for (int i = 1; i < 8; i++) begin
         wait_chg(20);
         chk(32'(cnt), 32'(i % 4));
      end
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_GATE, 1'b0, 1'b0));
      cyc(8);
      d = 32'(cnt);
      cyc(30);
      chk(32'(cnt), d);
   endtask : t_gate
   task t_one();
      logic [31:0] d;
      logic [1:0] r;
      do_reset();
      axw(`PTO_OFF_PERIOD, 32'h4);
      axw(`PTO_OFF_WIDTH, 32'h2);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_SW, 1'b0, 1'b1));
      wait_hi(1'b0, 12);
      for (int i = 1; i < 6; i++) begin
         wait_chg(20);
         chk(32'(cnt), 32'(i % 5));
         if (i >= 3) chk(32'(drv), 32'h0);
      end
      cyc(40);
      chk(32'(cnt), 32'h0);
      chk(32'(drv), 32'h0);
      axr(`PTO_OFF_CTRL, d, r);
      chk(d & 32'h1, 32'h0);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_SW, 1'b0, 1'b1));
      wait_hi(1'b0, 12);
   endtask : t_one
   task t_pause();
      logic [31:0] d;
      do_reset();
      axw(`PTO_OFF_PERIOD, 32'h6);
      axw(`PTO_OFF_WIDTH, 32'h4);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_SW, 1'b0, 1'b1));
      wait_chg(20);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_SW, 1'b0, 1'b0));
      cyc(12);
      d = 32'(cnt);
      cyc(40);
      chk(32'(cnt), d);
      chk(32'(drv), 32'h1);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_SW, 1'b0, 1'b1));
      wait_hi(1'b1, 80);
      cyc(2);
      chk(32'(drv), 32'h0);
   endtask : t_pause
   task t_edge(input logic [4:0] m);
      logic [31:0] d;
      logic [1:0] r;
      do_reset();
      lvl <= (m != `PTO_MODE_ONE_RISE);
      axw(`PTO_OFF_PERIOD, 32'h3);
      axw(`PTO_OFF_WIDTH, 32'h2);
      axw(`PTO_OFF_CTRL, ctrl(m, 1'b0, 1'b1));
      cyc(30);
      chk({24'h0, cnt} | 32'(drv), 32'h0);
      @(posedge clk_sys_i);
      lvl <= ~lvl;
      wait_hi(1'b0, 20);
      wait_hi(1'b1, 60);
      cyc(10);
      chk({24'h0, cnt} | 32'(drv), 32'h0);
      axr(`PTO_OFF_CTRL, d, r);
      chk(d & 32'h1, 32'h0);
   endtask : t_edge
   task t_rearm();
      logic [31:0] d;
      do_reset();
      lvl <= 1'b0;
      axw(`PTO_OFF_PERIOD, 32'h8);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_RISE, 1'b0, 1'b1));
      @(posedge clk_sys_i);
      lvl <= 1'b1;
      wait_chg(40);
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_RISE, 1'b0, 1'b0));
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_ONE_RISE, 1'b0, 1'b1));
      cyc(12);
      d = 32'(cnt);
      @(posedge clk_sys_i);
      lvl <= 1'b0;
      cyc(30);
      chk(32'(cnt), d);
      @(posedge clk_sys_i);
      lvl <= 1'b1;
      wait_chg(40);
      chk(32'(cnt), d + 32'h1);
   endtask : t_rearm
   task t_ext();
      logic [31:0] d;
      do_reset();
      ext_en <= 1'b1;
      axw(`PTO_OFF_CTRL, ctrl(`PTO_MODE_GATE, 1'b1, 1'b1));
      cyc(4);
      chk(32'(cnt), 32'h0);
      wait_chg(60);
      chk(32'(cnt), 32'h1);
      @(posedge clk_sys_i);
      ext_en <= 1'b0;
      cyc(12);
      d = 32'(cnt);
      cyc(40);
      chk(32'(cnt), d);
   endtask : t_ext
   initial begin
      t_gate();
      t_one();
      t_pause();
      t_edge(`PTO_MODE_ONE_RISE);
      t_edge(`PTO_MODE_ONE_FALL);
      t_edge(`PTO_MODE_ONE_BOTH);
      t_rearm();
      t_ext();
      conclude();
   end
endmodule : testbench
